/* common/adc_cfg_pkg.sv */
// constants for the front-end / high-pass configuration register bank
// assumes byte-wide command traffic already framed by the serial front end
package adc_cfg_pkg;

	// ****************************************
	// register indices
	// ****************************************
	localparam logic [4:0] ADDR_FRONT_END_CONFIG = 5'h02;
	localparam logic [4:0] ADDR_HIGHPASS_CORNER_LOW = 5'h03;
	localparam logic [4:0] ADDR_HIGHPASS_CORNER_HIGH = 5'h04;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_FRONT_END_CONFIG = 8'h08;
	localparam logic [7:0] RST_HIGHPASS_CORNER_LOW = 8'h32;
	localparam logic [7:0] RST_HIGHPASS_CORNER_HIGH = 8'h03;

	// ****************************************
	// front_end_config field layout
	// ****************************************
	localparam int RESERVED_BIT = 7;
	localparam int INPUT_SEL_MSB = 6;
	localparam int INPUT_SEL_LSB = 4;
	localparam int AMP_MOD_BIT = 3;
	localparam int GAIN_SEL_MSB = 2;
	localparam int GAIN_SEL_LSB = 0;

	// ****************************************
	// command encoding: opcode in bits 7:5, index in 4:0
	// ****************************************
	localparam logic [2:0] CMD_REGISTER_READ = 3'h1;
	localparam logic [2:0] CMD_REGISTER_WRITE = 3'h2;

	// ****************************************
	// timing
	// ****************************************
	localparam logic [5:0] RESTART_READINGS = 6'h3f;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_COUNT = 4'h2,
		ST_WRITE = 4'h4,
		ST_READ = 4'h8
	} cmd_state_t;

endpackage

/* core/adc_input_gain_hpf_config.sv */
// front-end and high-pass corner configuration bank behind a byte command port
// assumes the serial front end delivers one byte per i_byte_valid pulse
`timescale 1ns/10ps
`default_nettype none
module adc_input_gain_hpf_config
	import adc_cfg_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// command byte stream
	input wire logic i_byte_valid,
	input wire logic [7:0] i_byte,
	// read answer stream
	output logic o_rd_valid,
	output logic [7:0] o_rd_data,
	// conversion pipeline
	input wire logic i_reading_tick,
	output logic o_pipeline_restart,
	output logic o_results_valid,
	// front-end settings
	output logic o_amp_modulation_enable,
	output logic [2:0] o_input_select,
	output logic [2:0] o_gain_select,
	output logic [15:0] o_highpass_corner
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic is_cmd(input logic [7:0] b, input logic [2:0] op);
		is_cmd = (b[7:5] == op);
	endfunction

	// ****************************************
	// state
	// ****************************************
	cmd_state_t state;
	cmd_state_t next_state;
	logic [4:0] addr;
	logic [4:0] next_addr;
	logic [4:0] remaining;
	logic [4:0] next_remaining;
	logic is_write;
	logic next_is_write;
	logic [7:0] front_end_config;
	logic [7:0] next_front_end_config;
	logic [7:0] highpass_corner_low;
	logic [7:0] next_highpass_corner_low;
	logic [7:0] highpass_corner_high;
	logic [7:0] next_highpass_corner_high;
	logic next_rd_valid;
	logic [7:0] next_rd_data;
	logic next_pipeline_restart;

	// ****************************************
	// command decode and register update
	// ****************************************
	always_comb
	begin
		next_state = state;
		next_addr = addr;
		next_remaining = remaining;
		next_is_write = is_write;
		next_front_end_config = front_end_config;
		next_highpass_corner_low = highpass_corner_low;
		next_highpass_corner_high = highpass_corner_high;
		next_rd_valid = 1'b0;
		next_rd_data = o_rd_data;
		next_pipeline_restart = 1'b0;
		case (state)
			ST_IDLE:
			begin
				// bytes that are not a register command are ignored here
				if (i_byte_valid && (is_cmd(i_byte, CMD_REGISTER_READ)
					|| is_cmd(i_byte, CMD_REGISTER_WRITE)))
				begin
					next_addr = i_byte[4:0];
					next_is_write = is_cmd(i_byte, CMD_REGISTER_WRITE);
					next_state = ST_COUNT;
				end
			end
			ST_COUNT:
			begin
				if (i_byte_valid)
				begin
					// byte count minus one; upper bits must be zero
					next_remaining = i_byte[4:0];
					next_state = is_write ? ST_WRITE : ST_READ;
				end
			end
			ST_WRITE:
			begin
				// bytes are taken as they come; spacing is the host's duty
				if (i_byte_valid)
				begin
					if (addr == ADDR_FRONT_END_CONFIG)
					begin
						next_front_end_config = i_byte;
						next_front_end_config[RESERVED_BIT] = 1'b0;
					end
					else if (addr == ADDR_HIGHPASS_CORNER_LOW)
					begin
						next_highpass_corner_low = i_byte;
					end
					else if (addr == ADDR_HIGHPASS_CORNER_HIGH)
					begin
						next_highpass_corner_high = i_byte;
					end
					next_addr = addr + 5'h01;
					next_remaining = remaining - 5'h01;
					if (remaining == 5'h00)
					begin
						// restart only once the whole burst has landed
						next_pipeline_restart = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_READ:
			begin
				// each host byte clocks one register out
				if (i_byte_valid)
				begin
					if (addr == ADDR_FRONT_END_CONFIG)
					begin
						next_rd_data = front_end_config;
					end
					else if (addr == ADDR_HIGHPASS_CORNER_LOW)
					begin
						next_rd_data = highpass_corner_low;
					end
					else if (addr == ADDR_HIGHPASS_CORNER_HIGH)
					begin
						next_rd_data = highpass_corner_high;
					end
					else
					begin
						// indices outside this bank answer zero
						next_rd_data = 8'h00;
					end
					next_rd_valid = 1'b1;
					next_addr = addr + 5'h01;
					next_remaining = remaining - 5'h01;
					if (remaining == 5'h00)
					begin
						next_state = ST_IDLE;
					end
				end
			end
			default:
			begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			state <= ST_IDLE;
			addr <= 5'h00;
			remaining <= 5'h00;
			is_write <= 1'b0;
			front_end_config <= RST_FRONT_END_CONFIG;
			highpass_corner_low <= RST_HIGHPASS_CORNER_LOW;
			highpass_corner_high <= RST_HIGHPASS_CORNER_HIGH;
			o_rd_valid <= 1'b0;
			o_rd_data <= 8'h00;
			o_pipeline_restart <= 1'b0;
		end
		else
		begin
			state <= next_state;
			addr <= next_addr;
			remaining <= next_remaining;
			is_write <= next_is_write;
			front_end_config <= next_front_end_config;
			highpass_corner_low <= next_highpass_corner_low;
			highpass_corner_high <= next_highpass_corner_high;
			o_rd_valid <= next_rd_valid;
			o_rd_data <= next_rd_data;
			o_pipeline_restart <= next_pipeline_restart;
		end
	end

	// ****************************************
	// settings outputs, registered copies of the bank
	// ****************************************
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			o_amp_modulation_enable <= RST_FRONT_END_CONFIG[AMP_MOD_BIT];
			o_input_select <= RST_FRONT_END_CONFIG[INPUT_SEL_MSB:INPUT_SEL_LSB];
			o_gain_select <= RST_FRONT_END_CONFIG[GAIN_SEL_MSB:GAIN_SEL_LSB];
			o_highpass_corner <= {RST_HIGHPASS_CORNER_HIGH, RST_HIGHPASS_CORNER_LOW};
		end
		else
		begin
			o_amp_modulation_enable <= next_front_end_config[AMP_MOD_BIT];
			o_input_select <= next_front_end_config[INPUT_SEL_MSB:INPUT_SEL_LSB];
			o_gain_select <= next_front_end_config[GAIN_SEL_MSB:GAIN_SEL_LSB];
			// high byte on top, low byte below
			o_highpass_corner <= {next_highpass_corner_high, next_highpass_corner_low};
		end
	end

	// ****************************************
	// conversion restart
	// ****************************************
	pipeline_restart u_restart (
		.i_ref_clk(i_ref_clk),
		.i_rst_b(i_rst_b),
		.i_restart(next_pipeline_restart),
		.i_reading_tick(i_reading_tick),
		.o_results_valid(o_results_valid)
	);

endmodule
`default_nettype wire

/* core/pipeline_restart.sv */
// holds the conversion stream invalid for a fixed number of readings
// assumes i_reading_tick pulses once per conversion result
`timescale 1ns/10ps
`default_nettype none
module pipeline_restart
	import adc_cfg_pkg::*;
(
	// clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	// control
	input wire logic i_restart,
	input wire logic i_reading_tick,
	// status
	output logic o_results_valid
);

	logic [5:0] remaining;
	logic [5:0] next_remaining;
	logic next_results_valid;

	always_comb
	begin
		next_remaining = remaining;
		// a new restart reloads even mid-count
		if (i_restart)
		begin
			next_remaining = RESTART_READINGS;
		end
		else if (i_reading_tick && remaining != 6'h00)
		begin
			next_remaining = remaining - 6'h01;
		end
		next_results_valid = (next_remaining == 6'h00);
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_b)
		begin
			remaining <= 6'h00;
			o_results_valid <= 1'b1;
		end
		else
		begin
			remaining <= next_remaining;
			o_results_valid <= next_results_valid;
		end
	end

endmodule
`default_nettype wire

/* tb/adc_cfg_chk.sv */
// port assertions for the config bank
// assumes one clock, bound to every bank
`timescale 1ns/10ps
`default_nettype none
module adc_cfg_chk
(
	// watched ports
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_byte_valid,
	input wire logic i_reading_tick,
	input wire logic o_rd_valid,
	input wire logic o_pipeline_restart,
	input wire logic o_results_valid,
	input wire logic o_amp_modulation_enable,
	input wire logic [15:0] o_highpass_corner
);
	// ****
	// properties
	// ****
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	logic [6:0] ticks;
	// the bank's counter already takes a tick in the cycle after its restart
	always_ff @(posedge i_ref_clk)
		if (!i_rst_b)
			ticks <= 7'h00;
		else if (o_pipeline_restart)
			ticks <= {6'h00, i_reading_tick};
		else if (i_reading_tick && !o_results_valid)
			ticks <= ticks + 7'h01;
	reset_vals_a:
		assert property (disable iff (1'b0) !i_rst_b |=>
			o_amp_modulation_enable && o_highpass_corner == 16'h0332) else $error("bad reset");
	amp_modulation_enable_cause_a:
		assert property ($changed(o_amp_modulation_enable) |-> $past(i_byte_valid) ||
			!$past(i_rst_b)) else $error("amp_modulation_enable moved alone");
	corner_cause_a:
		assert property ($changed(o_highpass_corner) |-> $past(i_byte_valid) ||
			!$past(i_rst_b)) else $error("corner moved alone");
	restart_pulse_a:
		assert property (o_pipeline_restart |=> !o_pipeline_restart) else $error("long restart");
	restart_cause_a:
		assert property (o_pipeline_restart |-> $past(i_byte_valid) && !o_results_valid)
		else $error("restart wrong");
	valid_fall_a:
		assert property ($fell(o_results_valid) |-> o_pipeline_restart) else $error("valid fell");
	readings_a:
		assert property ($rose(o_results_valid) |-> ticks == 7'h3f || !$past(i_rst_b))
		else $error("not 63 readings");
	read_cause_a:
		assert property (o_rd_valid |-> $past(i_byte_valid)) else $error("stray read");
	cover property (o_pipeline_restart);
	cover property (o_rd_valid);
	cover property ($rose(o_results_valid));
endmodule
bind adc_input_gain_hpf_config adc_cfg_chk u_adc_cfg_chk (.i_ref_clk, .i_rst_b,
	.i_byte_valid, .i_reading_tick, .o_rd_valid, .o_pipeline_restart, .o_results_valid,
	.o_amp_modulation_enable, .o_highpass_corner);
`default_nettype wire

/* tb/host_cmd_model.sv */
// host model sending spaced command bytes
// assumes the bench calls wr and rd one at a time
`timescale 1ns/10ps
`default_nettype none
module host_cmd_model
(
	// clock
	input wire logic i_ref_clk,
	// byte stream
	output logic o_byte_valid,
	output logic [7:0] o_byte,
	// answers
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_data,
	input wire logic i_restart
);
	// ****
	// byte tasks
	// ****
	logic got_rd;
	logic got_restart;
	logic [7:0] got_data;
	initial
	begin
		o_byte_valid = 1'b0;
		o_byte = 8'h00;
	end
	task automatic send(input logic [7:0] b);
		@(posedge i_ref_clk);
		o_byte_valid <= 1'b1;
		o_byte <= b;
		@(posedge i_ref_clk);
		o_byte_valid <= 1'b0;
		// inverse so a stale byte never looks valid
		o_byte <= ~b;
		#1;
		got_rd = i_rd_valid;
		got_restart = i_restart;
		got_data = i_rd_data;
		repeat (22) @(posedge i_ref_clk);
	endtask
	task automatic wr(input logic [4:0] idx, input logic [7:0] d);
		send({3'h2, idx});
		send(8'h00);
		send(d);
	endtask
	task automatic rd(input logic [4:0] idx);
		send({3'h1, idx});
		send(8'h00);
		send(8'h00);
	endtask
endmodule
`default_nettype wire

/* tb/tb_adc_input_gain_hpf_config.sv */
// self-checking bench for the config bank
// assumes the host model spaces all bytes
`timescale 1ns/10ps
`default_nettype none
module tb_adc_input_gain_hpf_config;
	// ****
	// bench
	// ****
	typedef struct {logic [4:0] idx; logic [7:0] wd; logic [7:0] rd;} row_t;
	row_t rows [4] = '{'{5'h02, 8'hf7, 8'h77}, '{5'h03, 8'ha5, 8'ha5},
		'{5'h04, 8'h5a, 8'h5a}, '{5'h05, 8'hff, 8'h00}};
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic tick = 1'b0;
	logic [1:0] tdiv = 2'h0;
	logic bv, rv, rs, ok, amp_modulation_enable;
	logic [7:0] bt, rdat;
	logic [2:0] sel, gain;
	logic [15:0] corner;
	int fail_count = 0;
	int num_checks = 0;
	always #25 clk = ~clk;
	always @(posedge clk)
	begin
		tdiv <= tdiv + 2'h1;
		tick <= (tdiv == 2'h3);
	end
	host_cmd_model u_host_cmd_model (.i_ref_clk(clk), .o_byte_valid(bv), .o_byte(bt),
		.i_rd_valid(rv), .i_rd_data(rdat), .i_restart(rs));
	adc_input_gain_hpf_config u_adc_input_gain_hpf_config (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_byte_valid(bv), .i_byte(bt), .o_rd_valid(rv), .o_rd_data(rdat),
		.i_reading_tick(tick), .o_pipeline_restart(rs), .o_results_valid(ok),
		.o_amp_modulation_enable(amp_modulation_enable), .o_input_select(sel), .o_gain_select(gain),
		.o_highpass_corner(corner));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rb(input logic [4:0] idx, input logic [7:0] exp);
		u_host_cmd_model.rd(idx);
		chk(u_host_cmd_model.got_rd, 1'b1);
		chk(u_host_cmd_model.got_data, exp);
	endtask
	task automatic print_verdict();
		$display("checks=%0d fails=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic do_reset();
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		chk({ok, amp_modulation_enable, sel, gain, corner}, 24'hc00332);
		rb(5'h02, 8'h08);
		rb(5'h03, 8'h32);
		rb(5'h04, 8'h03);
	endtask
	initial
	begin
		do_reset();
		foreach (rows[i])
		begin
			u_host_cmd_model.wr(rows[i].idx, rows[i].wd);
			chk({u_host_cmd_model.got_restart, ok}, 2'h2);
			rb(rows[i].idx, rows[i].rd);
		end
		chk({amp_modulation_enable, sel, gain, corner}, 23'h3f5aa5);
		u_host_cmd_model.send(8'h42);
		u_host_cmd_model.send(8'h02);
		u_host_cmd_model.send(8'h0c);
		u_host_cmd_model.send(8'h34);
		chk(u_host_cmd_model.got_restart, 1'b0);
		u_host_cmd_model.send(8'h12);
		chk({u_host_cmd_model.got_restart, amp_modulation_enable, gain, corner}, 21'h1c1234);
		// look just after each edge so the flop has settled
		for (int n = 0; n < 400 && ok !== 1'b1; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk(ok, 1'b1);
		u_host_cmd_model.send(8'h23);
		u_host_cmd_model.send(8'h01);
		u_host_cmd_model.send(8'h00);
		chk(u_host_cmd_model.got_data, 8'h34);
		u_host_cmd_model.send(8'h00);
		chk(u_host_cmd_model.got_data, 8'h12);
		do_reset();
		print_verdict();
	end
	initial
	begin
		// about 1460 cycles expected; limit at 4000
		#200000;
		fail_count++;
		print_verdict();
	end
endmodule
`default_nettype wire
